// ### core/txcs_core.sv
// Purpose: Transmit cell scheduler timing, primitives, throttle and ABR supervision
// Assumes: One active channel context presented on i_desc; synchronous inputs
// Notes:   Registers reached through a simple write/read strobe port
module txcs_core #(
  parameter longint P_RM_BOUND_CYC = txcs_pkg::RM_BOUND_CYC
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic [31:0]          i_reg_wdata,
  output logic      [31:0]          o_reg_rdata,
  input  wire txcs_pkg::txcs_desc_t  i_desc,
  input  wire txcs_pkg::txcs_sched_t i_chan_sched,
  input  wire txcs_pkg::txcs_sched_t i_path_sched,
  input  wire logic                 i_phy_pos,
  input  wire logic                 i_work_ready,
  input  wire logic                 i_cell_accept,
  output logic                      o_cell_req,
  input  wire logic                 i_pkt_done,
  input  wire logic [15:0]          i_pkt_blocks,
  output logic      [31:0]          o_next_start,
  output logic                      o_frame_mode,
  output logic                      o_prepend_header,
  output txcs_pkg::txcs_sched_t     o_sched,
  output logic                      o_share_per_packet,
  output logic                      o_lowq_frame_wfq,
  output logic                      o_enq_valid,
  output logic      [31:0]          o_enq_data,
  output logic                      o_close_req,
  output logic                      o_close_drain,
  output logic      [31:0]          o_close_addr,
  input  wire logic                 i_seg_stopped,
  output logic                      o_close_event,
  input  wire logic [31:0]          i_timer_period,
  output logic                      o_dma_exec,
  output logic      [31:0]          o_dma_ptr,
  input  wire logic                 i_abr_cell_sent,
  input  wire logic                 i_rm_sent,
  output logic                      o_rm_due,
  output logic                      o_rate_to_icr,
  output logic      [15:0]          o_new_rate,
  output logic                      o_suspended,
  input  wire logic                 i_pcr_valid,
  input  wire logic [32:0]          i_pcr_value,
  output logic                      o_pcr_valid,
  output logic      [31:0]          o_pcr_slot,
  input  wire logic [31:0]          i_serviced_count,
  output logic                      o_work_pending,
  output logic      [31:0]          o_timeslot
);

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  wire logic wr_enq      = i_reg_wr && hit(i_reg_addr, txcs_pkg::OFF_ENQUEUE);
  wire logic wr_resume   = i_reg_wr && hit(i_reg_addr, txcs_pkg::OFF_RESUME);
  wire logic wr_timer    = i_reg_wr && hit(i_reg_addr, txcs_pkg::OFF_TIMER);
  wire logic wr_close    = i_reg_wr && hit(i_reg_addr, txcs_pkg::OFF_CLOSE);
  wire logic wr_prescale = i_reg_wr && hit(i_reg_addr, txcs_pkg::OFF_PRESCALE);
  wire logic wr_control  = i_reg_wr && hit(i_reg_addr, txcs_pkg::OFF_CONTROL);
  wire logic wr_thr      = i_reg_wr && hit(i_reg_addr, txcs_pkg::OFF_THR_VALUE);
  wire logic wr_mpeg     = i_reg_wr && hit(i_reg_addr, txcs_pkg::OFF_MPEG);

  logic [23:0] prescale;
  logic [23:0] accum;
  logic [31:0] control;
  logic [31:0] thr_value;
  logic [31:0] thr_count;
  logic [14:0] mpeg_factor;

  logic [31:0] rd_mux;
  always_comb begin
    if (hit(i_reg_addr, txcs_pkg::OFF_PRESCALE)) begin
      rd_mux = {8'h00, prescale};
    end else if (hit(i_reg_addr, txcs_pkg::OFF_TIMESLOT)) begin
      rd_mux = o_timeslot;
    end else if (hit(i_reg_addr, txcs_pkg::OFF_CONTROL)) begin
      rd_mux = control;
    end else if (hit(i_reg_addr, txcs_pkg::OFF_THR_VALUE)) begin
      rd_mux = thr_value;
    end else if (hit(i_reg_addr, txcs_pkg::OFF_THR_COUNT)) begin
      rd_mux = thr_count;
    end else if (hit(i_reg_addr, txcs_pkg::OFF_MPEG)) begin
      rd_mux = {17'h00000, mpeg_factor};
    end else begin
      // Write-only primitive ports and unmapped offsets read as zero
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 32'h0000_0000;
      prescale    <= txcs_pkg::PRESCALE_RST;
      control     <= txcs_pkg::CONTROL_RST;
      thr_value   <= txcs_pkg::THR_RST;
      mpeg_factor <= txcs_pkg::MPEG_RST;
    end else begin
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
      if (wr_prescale) begin
        prescale <= i_reg_wdata[23:0];
      end
      if (wr_control) begin
        control <= i_reg_wdata;
      end
      if (wr_thr) begin
        thr_value <= i_reg_wdata;
      end
      if (wr_mpeg) begin
        mpeg_factor <= i_reg_wdata[14:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeslot prescaler and counter
  wire logic [23:0] next_accum = accum + prescale;
  wire logic        slot_tick  = next_accum[txcs_pkg::ACC_TOP_BIT] != accum[txcs_pkg::ACC_TOP_BIT];

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      accum      <= 24'h000000;
      o_timeslot <= 32'h0000_0000;
    end else begin
      accum <= next_accum;
      if (slot_tick) begin
        o_timeslot <= o_timeslot + 32'h0000_0001;
      end
    end
  end

  // Modular compare: any difference means a slot awaits service
  assign o_work_pending = (o_timeslot - i_serviced_count) != 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Scheduling parameter selection and frame mode
  assign o_frame_mode       = i_phy_pos;
  assign o_prepend_header   = !i_phy_pos;
  assign o_sched            = i_desc.path_shared ? i_path_sched : i_chan_sched;
  assign o_share_per_packet = i_desc.share_per_packet;
  assign o_lowq_frame_wfq   = control[txcs_pkg::CTRL_LOWQ_WFQ_BIT];

  wire logic        pkt_wfq   = o_lowq_frame_wfq && i_desc.lowq;
  wire logic [31:0] frame_gap = pkt_wfq ? {16'h0000, o_sched.avg}
                                        : o_sched.peak * i_pkt_blocks;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_next_start <= 32'h0000_0000;
    end else if (i_pkt_done && o_frame_mode) begin
      o_next_start <= o_timeslot + frame_gap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segmentation throttle and cell request
  logic [15:0] cells_since_rm;
  wire logic [16:0] rm_budget  = (17'h00001 << i_desc.nrm) + 17'h00001;
  wire logic        budget_out = i_desc.abr && ({1'b0, cells_since_rm} >= rm_budget);

  // Request withheld while throttling, or on ABR channels while suspended or out of RM budget
  assign o_cell_req = i_work_ready && (thr_count == 32'h0000_0000)
                      && !(i_desc.abr && (o_suspended || budget_out));

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      thr_count <= 32'h0000_0000;
    end else if (i_cell_accept) begin
      thr_count <= thr_value;
    end else if (thr_count != 32'h0000_0000) begin
      thr_count <= thr_count - 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ABR supervision
  logic [31:0] rm_time;
  logic        rate_decrease_time_factor_fired;
  wire logic [31:0] rm_bound   = 32'(P_RM_BOUND_CYC) >> i_desc.trm;
  wire logic [31:0] rate_decrease_time_factor_limit = 32'(i_desc.rate_decrease_time_factor) * 32'(txcs_pkg::RATE_DECREASE_TIME_FACTOR_UNIT_CYC);
  wire logic        time_due   = rm_time >= rm_bound;
  wire logic        rate_decrease_time_factor_event = i_desc.abr && !rate_decrease_time_factor_fired && (i_desc.rate_decrease_time_factor != 10'h000)
                                 && (rm_time >= rate_decrease_time_factor_limit);
  wire logic        crm_event  = i_desc.abr && budget_out && time_due;
  wire logic        ccr0_event = i_desc.abr && (i_desc.current_cell_rate == 16'h0000);

  assign o_rm_due = i_desc.abr && (budget_out || time_due);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rm_time        <= 32'h0000_0000;
      cells_since_rm <= 16'h0000;
      rate_decrease_time_factor_fired     <= 1'b0;
      o_rate_to_icr  <= 1'b0;
      o_new_rate     <= 16'h0000;
      o_suspended    <= 1'b0;
    end else begin
      o_rate_to_icr <= rate_decrease_time_factor_event;
      if (rate_decrease_time_factor_event) begin
        o_new_rate <= i_desc.initial_cell_rate;
      end
      if (i_rm_sent) begin
        rm_time        <= 32'h0000_0000;
        cells_since_rm <= 16'h0000;
        rate_decrease_time_factor_fired     <= 1'b0;
      end else begin
        if (rm_time != 32'hffff_ffff) begin
          rm_time <= rm_time + 32'h0000_0001;
        end
        if (i_abr_cell_sent && cells_since_rm != 16'hffff) begin
          cells_since_rm <= cells_since_rm + 16'h0001;
        end
        if (rate_decrease_time_factor_event) begin
          rate_decrease_time_factor_fired <= 1'b1;
        end
      end
      // A suspending event in the resume cycle wins
      if (rate_decrease_time_factor_event || crm_event || ccr0_event) begin
        o_suspended <= 1'b1;
      end else if (wr_resume) begin
        o_suspended <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Primitives: enqueue, close, timer
  txcs_pkg::txcs_close_t close_state;
  logic        timer_run;
  logic [31:0] timer_count;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_enq_valid   <= 1'b0;
      o_enq_data    <= 32'h0000_0000;
      o_close_req   <= 1'b0;
      o_close_drain <= 1'b0;
      o_close_addr  <= 32'h0000_0000;
      o_close_event <= 1'b0;
      close_state   <= txcs_pkg::CL_IDLE;
    end else begin
      o_enq_valid   <= wr_enq;
      o_close_req   <= 1'b0;
      o_close_event <= 1'b0;
      if (wr_enq) begin
        o_enq_data <= i_reg_wdata;
      end
      case (close_state)
        txcs_pkg::CL_IDLE: begin
          if (wr_close) begin
            o_close_req   <= 1'b1;
            o_close_drain <= control[txcs_pkg::CTRL_CLOSE_DRAIN_BIT];
            o_close_addr  <= i_reg_wdata;
            close_state   <= txcs_pkg::CL_WAIT;
          end
        end
        txcs_pkg::CL_WAIT: begin
          if (i_seg_stopped) begin
            o_close_event <= 1'b1;
            close_state   <= txcs_pkg::CL_IDLE;
          end
        end
        default: begin
          close_state <= txcs_pkg::CL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      timer_run   <= 1'b0;
      timer_count <= 32'h0000_0000;
      o_dma_exec  <= 1'b0;
      o_dma_ptr   <= 32'h0000_0000;
    end else begin
      o_dma_exec <= 1'b0;
      if (wr_timer) begin
        timer_run   <= !i_reg_wdata[txcs_pkg::TIMER_STOP_BIT];
        timer_count <= i_timer_period;
      end else if (timer_run) begin
        if (timer_count == 32'h0000_0000) begin
          timer_run  <= 1'b0;
          o_dma_exec <= 1'b1;
          o_dma_ptr  <= i_desc.dma_ptr;
        end else begin
          timer_count <= timer_count - 32'h0000_0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // MPEG clock reference conversion
  wire logic [47:0] pcr_product = 48'(i_pcr_value) * 48'(mpeg_factor);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pcr_valid <= 1'b0;
      o_pcr_slot  <= 32'h0000_0000;
    end else begin
      o_pcr_valid <= i_pcr_valid && i_desc.mpeg;
      if (i_pcr_valid && i_desc.mpeg) begin
        o_pcr_slot <= pcr_product[txcs_pkg::MPEG_FRAC_BITS +: 32];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_slot_tick;
    slot_tick |=> o_timeslot == $past(o_timeslot) + 32'h0000_0001;
  endproperty
  a_slot_tick: assert property (p_slot_tick) else $error("timeslot missed a tick");

  property p_slot_hold;
    !slot_tick |=> $stable(o_timeslot);
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("timeslot moved without tick");

  property p_throttle;
    i_cell_accept && !wr_thr
      |=> thr_count == $past(thr_value) && (thr_count == 32'h0000_0000 || !o_cell_req);
  endproperty
  a_throttle: assert property (p_throttle) else $error("throttle not loaded");

  property p_suspend_hold;
    o_suspended && !wr_resume |=> o_suspended;
  endproperty
  a_suspend_hold: assert property (p_suspend_hold) else $error("suspend dropped early");

  property p_close;
    wr_close && close_state == txcs_pkg::CL_IDLE ##1 !i_seg_stopped [*2] ##1 i_seg_stopped
      |=> o_close_event;
  endproperty
  a_close: assert property (p_close) else $error("close event missing");

  property p_timer;
    timer_run && timer_count == 0 && !wr_timer |=> o_dma_exec && !timer_run;
  endproperty
  a_timer: assert property (p_timer) else $error("timer expiry lost");

  property p_timer_start;
    wr_timer |=> timer_run == !$past(i_reg_wdata[0]);
  endproperty
  a_timer_start: assert property (p_timer_start) else $error("timer start/stop wrong");

  property p_frame;
    i_pkt_done && i_phy_pos && !pkt_wfq
      |=> o_next_start == $past(o_timeslot) + $past(o_sched.peak) * $past(i_pkt_blocks);
  endproperty
  a_frame: assert property (p_frame) else $error("frame spacing wrong");

  property p_icr;
    rate_decrease_time_factor_event |=> o_rate_to_icr && o_new_rate == $past(i_desc.initial_cell_rate) && o_suspended;
  endproperty
  a_icr: assert property (p_icr) else $error("rate not dropped to initial");

  c_tick:    cover property (slot_tick ##1 slot_tick [*1]);
  c_close:   cover property (o_close_req ##[1:20] o_close_event);
  c_dma:     cover property (wr_timer ##[1:50] o_dma_exec);
  c_resume:  cover property (o_suspended ##1 wr_resume ##1 !o_suspended);

endmodule

// ### pkg/txcs_pkg.sv
// Purpose: Shared constants and carriers for the transmit cell scheduler
// Assumes: 20 MHz system clock, 32-bit register port with byte offsets
// Notes:   Prescaler reset is derived from clock period and SONET payload rate
package txcs_pkg;

  // Register offsets
  localparam logic [7:0] OFF_ENQUEUE   = 8'h00;
  localparam logic [7:0] OFF_RESUME    = 8'h04;
  localparam logic [7:0] OFF_TIMER     = 8'h08;
  localparam logic [7:0] OFF_CLOSE     = 8'h0c;
  localparam logic [7:0] OFF_PRESCALE  = 8'h10;
  localparam logic [7:0] OFF_TIMESLOT  = 8'h14;
  localparam logic [7:0] OFF_CONTROL   = 8'h18;
  localparam logic [7:0] OFF_THR_VALUE = 8'h1c;
  localparam logic [7:0] OFF_THR_COUNT = 8'h20;
  localparam logic [7:0] OFF_MPEG      = 8'h24;

  // Field positions
  localparam int CTRL_CLOSE_DRAIN_BIT = 0;
  localparam int CTRL_LOWQ_WFQ_BIT    = 17;
  localparam int TIMER_STOP_BIT       = 0;
  localparam int MPEG_FRAC_BITS       = 12;
  localparam int ACC_TOP_BIT          = 23;

  // Timing
  localparam longint CLK_PERIOD_NS    = 50;
  localparam longint CELL_BITS        = 424;
  localparam longint PAYLOAD_KBPS     = 599040;
  localparam longint RM_BOUND_MS      = 100;
  localparam longint RATE_DECREASE_TIME_FACTOR_UNIT_NS     = 10000;
  localparam int     RATE_DECREASE_TIME_FACTOR_UNIT_CYC    = int'((RATE_DECREASE_TIME_FACTOR_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam longint RM_BOUND_CYC     = RM_BOUND_MS * 1000000 / CLK_PERIOD_NS;

  // Reset values
  localparam logic [23:0] PRESCALE_RST =
    24'((CLK_PERIOD_NS * PAYLOAD_KBPS * (64'd1 << 23)) / (CELL_BITS * 1000000));
  localparam logic [14:0] MPEG_RST     = 15'h3ecb;
  localparam logic [31:0] CONTROL_RST  = 32'h0000_0000;
  localparam logic [31:0] THR_RST      = 32'h0000_0000;

  typedef struct packed {
    logic [15:0] peak;
    logic [15:0] avg;
  } txcs_sched_t;

  typedef struct packed {
    logic        abr;
    logic [3:0]  nrm;
    logic [3:0]  trm;
    logic [9:0]  rate_decrease_time_factor;
    logic [15:0] initial_cell_rate;
    logic [15:0] current_cell_rate;
    logic        path_shared;
    logic        share_per_packet;
    logic        mpeg;
    logic        lowq;
    logic [31:0] dma_ptr;
  } txcs_desc_t;

  typedef enum logic [1:0] {
    CL_IDLE = 2'b01,
    CL_WAIT = 2'b10
  } txcs_close_t;

endpackage

// ### verification/txcs_core_bench.sv
// Purpose: Self-checking bench for the transmit cell scheduler core
// Assumes: RM bound shortened to 1000 cycles
// Notes:   Watcher pops expected notes in order as results appear
module txcs_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    string       nm;
    logic [31:0] v;
  } txcs_note_t;
  txcs_note_t           notes[$];
  int                   error_cnt = 0;
  int                   total_checks = 0;
  int                   seed, cyc = 0, t_wr = 0, g;
  logic                 clock, rst_n, reg_wr, reg_rd, rd_d = 1'b0, slow;
  logic                 phy_pos, work_ready, cell_accept, cell_req, pkt_done;
  logic                 enq_valid, close_req, close_drain, seg_stopped, close_event;
  logic                 dma_exec, abr_sent, rm_sent, rm_due, rate_icr, suspended;
  logic                 pcr_in, pcr_out, work_pending, frame_mode, prepend, share_pp, wfq;
  logic [7:0]           reg_addr;
  logic [15:0]          pkt_blocks, new_rate;
  logic [31:0]          reg_wdata, reg_rdata, next_start, enq_data, close_addr, timer_period;
  logic [31:0]          dma_ptr, pcr_slot, serviced, timeslot, a, t0;
  logic [32:0]          pcr_value;
  txcs_pkg::txcs_desc_t desc;
  txcs_pkg::txcs_sched_t chan_sched, path_sched, sched;
  ////////////////////////////////////////////////////////////////
  txcs_core #(.P_RM_BOUND_CYC(1000)) i_txcs_core (
    .i_clock(clock), .i_rst_n(rst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_desc(desc), .i_chan_sched(chan_sched), .i_path_sched(path_sched),
    .i_phy_pos(phy_pos), .i_work_ready(work_ready), .i_cell_accept(cell_accept),
    .o_cell_req(cell_req), .i_pkt_done(pkt_done), .i_pkt_blocks(pkt_blocks),
    .o_next_start(next_start), .o_frame_mode(frame_mode), .o_prepend_header(prepend),
    .o_sched(sched), .o_share_per_packet(share_pp), .o_lowq_frame_wfq(wfq),
    .o_enq_valid(enq_valid), .o_enq_data(enq_data), .o_close_req(close_req),
    .o_close_drain(close_drain), .o_close_addr(close_addr), .i_seg_stopped(seg_stopped),
    .o_close_event(close_event), .i_timer_period(timer_period), .o_dma_exec(dma_exec),
    .o_dma_ptr(dma_ptr), .i_abr_cell_sent(abr_sent), .i_rm_sent(rm_sent), .o_rm_due(rm_due),
    .o_rate_to_icr(rate_icr), .o_new_rate(new_rate), .o_suspended(suspended),
    .i_pcr_valid(pcr_in), .i_pcr_value(pcr_value), .o_pcr_valid(pcr_out),
    .o_pcr_slot(pcr_slot), .i_serviced_count(serviced), .o_work_pending(work_pending),
    .o_timeslot(timeslot));
  txcs_seg_model i_txcs_seg_model (
    .i_clock(clock), .i_rst_n(rst_n), .i_slow(slow), .i_cell_req(cell_req),
    .i_close_req(close_req), .o_work_ready(work_ready), .o_cell_accept(cell_accept),
    .o_seg_stopped(seg_stopped));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic take(input string nm, input logic [31:0] seen);
    txcs_note_t n;
    n = '{nm, 32'hx};
    if (notes.size() != 0) n = notes.pop_front();
    check({nm, "/", n.nm}, seen, n.v);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    notes.push_back('{"rdata", exp});
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task automatic pulse(input int k, input logic [32:0] v);
    @(posedge clock);
    pkt_done <= (k == 0);
    pkt_blocks <= v[15:0];
    rm_sent <= (k == 1);
    abr_sent <= (k == 2);
    pcr_in <= (k == 3);
    pcr_value <= v;
    @(posedge clock);
    {pkt_done, rm_sent, abr_sent, pcr_in} <= 4'h0;
    @(negedge clock);
  endtask
  task automatic wait_acc();
    g = 0;
    do begin
      @(negedge clock);
      g++;
    end while (!cell_accept && g < 100);
  endtask
  task automatic wrap_up();
    if (notes.size() != 0) error_cnt++;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cyc <= cyc + 1;
    rd_d <= reg_rd;
    if (reg_wr && reg_addr == txcs_pkg::OFF_TIMER) t_wr <= cyc;
  end
  always @(negedge clock) begin
    if (rd_d) take("rdata", reg_rdata);
    if (enq_valid) take("enq", enq_data);
    if (close_req) take("close", {close_drain, close_addr[30:0]});
    if (close_event) take("close_event", 32'h1);
    if (dma_exec) take("dma_ptr", dma_ptr);
    if (dma_exec) take("dma_delay", 32'(cyc - t_wr));
    if (pcr_out) take("pcr", pcr_slot);
    if (rate_icr) take("new_rate", {16'h0, new_rate});
  end
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    wrap_up();
  end
  initial begin
    seed = 13670;
    {rst_n, reg_wr, reg_rd, phy_pos, pkt_done, abr_sent, rm_sent, pcr_in, slow} = '0;
    {reg_addr, pkt_blocks, reg_wdata, timer_period, serviced, pcr_value} = '0;
    {desc, chan_sched, path_sched} = '0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(txcs_pkg::OFF_PRESCALE, {8'h0, txcs_pkg::PRESCALE_RST});
    rd(txcs_pkg::OFF_MPEG, 32'h3ecb);
    rd(txcs_pkg::OFF_ENQUEUE, 32'h0);
    rd(8'h40, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(txcs_pkg::OFF_PRESCALE, 32'h80_0000 >> k);
      @(negedge clock);
      t0 = timeslot;
      repeat (16) @(negedge clock);
      check("timeslot step", timeslot - t0, 32'h10 >> k);
      // Far enough ahead that one more tick cannot close the gap
      serviced <= timeslot + 32'h10;
      @(negedge clock);
      check("pending", work_pending, 1'b1);
    end
    wr(txcs_pkg::OFF_PRESCALE, 32'h0);
    // Let the last tick under the old prescale settle first
    @(negedge clock);
    serviced <= timeslot;
    @(negedge clock);
    check("idle", work_pending, 1'b0);
    for (int p = 0; p < 2; p++) begin
      phy_pos <= p[0];
      desc.path_shared <= p[0];
      desc.share_per_packet <= $random(seed);
      chan_sched <= $random(seed);
      path_sched <= $random(seed);
      @(negedge clock);
      check("frame", {frame_mode, prepend}, {p[0], !p[0]});
      check("sched", sched, p[0] ? path_sched : chan_sched);
      check("share", share_pp, desc.share_per_packet);
    end
    chan_sched.peak <= 16'h3;
    desc.path_shared <= 1'b0;
    a = $random(seed) & 32'hff;
    pulse(0, a);
    check("next start", next_start, timeslot + 32'h3 * a);
    wr(txcs_pkg::OFF_CONTROL, 32'h2_0000);
    desc.lowq <= 1'b1;
    pulse(0, 33'h9);
    check("wfq start", next_start, timeslot + chan_sched.avg);
    check("wfq flag", wfq, 1'b1);
    for (int e = 0; e < 2; e++) begin
      a = $random(seed);
      notes.push_back('{"enq", a});
      wr(txcs_pkg::OFF_ENQUEUE, a);
    end
    for (int t = 0; t < 4; t += 3) begin
      wr(txcs_pkg::OFF_THR_VALUE, t);
      wait_acc();
      wait_acc();
      check("throttle gap", g, t + 2);
    end
    wr(txcs_pkg::OFF_THR_VALUE, 32'h0);
    desc.dma_ptr <= $random(seed);
    timer_period <= 32'h3;
    @(negedge clock);
    notes.push_back('{"dma_ptr", desc.dma_ptr});
    notes.push_back('{"dma_delay", 32'h5});
    wr(txcs_pkg::OFF_TIMER, 32'h0);
    repeat (10) @(posedge clock);
    timer_period <= 32'h14;
    wr(txcs_pkg::OFF_TIMER, 32'h0);
    wr(txcs_pkg::OFF_TIMER, 32'h1);
    repeat (30) @(posedge clock);
    for (int d = 0; d < 2; d++) begin
      wr(txcs_pkg::OFF_CONTROL, d);
      slow <= d[0];
      a = $random(seed);
      notes.push_back('{"close", {d[0], a[30:0]}});
      notes.push_back('{"close_event", 32'h1});
      wr(txcs_pkg::OFF_CLOSE, a);
      wr(txcs_pkg::OFF_CLOSE, ~a);
      repeat (12) @(posedge clock);
    end
    desc.mpeg <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      g = m ? ($random(seed) & 32'h7fff) : 32'h3ecb;
      if (m) wr(txcs_pkg::OFF_MPEG, g);
      if (m) rd(txcs_pkg::OFF_MPEG, g);
      pcr_value <= {$random(seed), $random(seed)};
      @(negedge clock);
      notes.push_back('{"pcr", 32'((48'(pcr_value) * 48'(g)) >> 12)});
      pulse(3, pcr_value);
      @(negedge clock);
    end
    desc.mpeg <= 1'b0;
    pulse(3, 33'h1234);
    desc <= '{abr: 1'b1, nrm: 4'h2, trm: 4'h1, initial_cell_rate: 16'h5a, current_cell_rate: 16'h7, default: '0};
    pulse(1, 33'h0);
    for (int c = 0; c < 5; c++) begin
      check("rm due early", rm_due, 1'b0);
      pulse(2, 33'h0);
    end
    check("rm due count", rm_due, 1'b1);
    check("req blocked", cell_req, 1'b0);
    pulse(1, 33'h0);
    repeat (488) @(negedge clock);
    check("rm time early", rm_due, 1'b0);
    repeat (20) @(negedge clock);
    check("rm time due", rm_due, 1'b1);
    notes.push_back('{"new_rate", 32'h5a});
    pulse(1, 33'h0);
    // Armed only after the RM gap restarts, else it fires at once
    desc.rate_decrease_time_factor <= 10'h1;
    repeat (215) @(negedge clock);
    check("rate_decrease_time_factor suspend", {suspended, cell_req}, 2'b10);
    pulse(1, 33'h0);
    wr(txcs_pkg::OFF_RESUME, 32'h0);
    @(negedge clock);
    check("resumed", suspended, 1'b0);
    desc.current_cell_rate <= 16'h0;
    repeat (3) @(negedge clock);
    check("zero rate", suspended, 1'b1);
    desc <= '0;
    wr(txcs_pkg::OFF_RESUME, 32'h0);
    @(negedge clock);
    check("resumed", suspended, 1'b0);
    repeat (5) @(posedge clock);
    wrap_up();
  end
endmodule

// ### verification/txcs_seg_model.sv
// Purpose: Segmentation-side model answering cell and close requests
// Assumes: Data always waiting; one close outstanding at a time
// Notes:   Slow mode delays the stopped indication to open a refusal window
module txcs_seg_model (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_slow,
  input  wire logic i_cell_req,
  input  wire logic i_close_req,
  output logic      o_work_ready,
  output logic      o_cell_accept,
  output logic      o_seg_stopped
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] stop_wait;
  ////////////////////////////////////////////////////////////////
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_work_ready  <= 1'b0;
      o_cell_accept <= 1'b0;
      o_seg_stopped <= 1'b0;
      stop_wait     <= 4'h0;
    end else begin
      o_work_ready  <= 1'b1;
      // A request must be seen again after each accept
      o_cell_accept <= i_cell_req && !o_cell_accept;
      if (i_close_req) begin
        stop_wait <= i_slow ? 4'h6 : 4'h1;
      end else if (stop_wait != 4'h0) begin
        stop_wait <= stop_wait - 4'h1;
      end
      o_seg_stopped <= (stop_wait == 4'h1);
    end
  end
endmodule
